// ===== rtl/sbc_defines.vh
`ifndef SBC_DEFINES_VH
`define SBC_DEFINES_VH

// ****************************************************************
// Frame layout
// ****************************************************************
`define SBC_FRAME_BITS 5'd16
`define SBC_ADDR_DIAG 3'b001
`define SBC_ADDR_STAT 3'b000
`define SBC_RO_BIT 12

// ****************************************************************
// Diagnosis word fields
// ****************************************************************
`define SBC_DG_GSD 11
`define SBC_DG_FAIL_HI 10
`define SBC_DG_FAIL_LO 7
`define SBC_DG_V3 4
`define SBC_DG_V2 3
`define SBC_DG_V1 2

// ****************************************************************
// Status word fields
// ****************************************************************
`define SBC_ST_RSS_HI 11
`define SBC_ST_RSS_LO 8
`define SBC_ST_WAKE 4
`define SBC_ST_TEMP 3
`define SBC_ST_SDM 2
`define SBC_ST_EN 1
`define SBC_ST_PWON 0
`define SBC_RSS_RESET 4'h0

// ****************************************************************
// Bus failure codes
// ****************************************************************
`define SBC_F_TXD_DOM 4'hf
`define SBC_F_RXD_DOM 4'he
`define SBC_F_RXD_REC 4'hd
`define SBC_F_BUS_DOM 4'hc
`define SBC_F_H_L 4'h9
`define SBC_F_L_SUP 4'h8
`define SBC_F_H_GND 4'h6
`define SBC_F_L_GND 4'h5
`define SBC_F_H_SUP 4'h4
`define SBC_F_NONE 4'h0

`endif

// ===== rtl/sbc_sync.v
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Two flip-flop synchroniser for a vector of unrelated levels
// ****************************************************************
module sbc_sync #(
  parameter WIDTH = 1
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);

  // First stage, read only by the second stage.
  reg [WIDTH-1:0] meta_reg;
  // Second stage, safe for logic.
  reg [WIDTH-1:0] stable_reg;

  // Both stages clear on reset so no stray edge is seen.
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      meta_reg <= {WIDTH{1'b0}};
      stable_reg <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_i;
      stable_reg <= meta_reg;
    end
  end

  assign sync_o = stable_reg;

endmodule // sbc_sync

`default_nettype wire

// ===== rtl/sbc_status_diag.v
`timescale 1ns/1ns
`default_nettype none
`include "sbc_defines.vh"

// ****************************************************************
// Status and diagnosis registers behind the 16-bit serial link
// ****************************************************************
module sbc_status_diag (
  input wire core_clk_i,
  input wire rst_i,
  // Serial link pins; the inputs are asynchronous, the outputs come from core clock flops.
  input wire link_sclk_i,
  input wire link_csn_i,
  input wire link_mosi_i,
  output wire link_miso_o,
  output wire link_miso_oe_o,
  // Analog and pin conditions, asynchronous.
  input wire wake_level_i,
  input wire temp_warning_i,
  input wire sw_dev_mode_i,
  input wire enable_output_i,
  input wire ground_shift_i,
  input wire mcu_undervolt_i,
  input wire [8:0] bus_fault_i,
  input wire aux_overload_i,
  input wire aux_reg_on_i,
  input wire bus_overload_i,
  input wire bus_reg_on_i,
  // Events from the core logic on the same clock.
  input wire power_on_event_i,
  input wire normal_entered_i,
  input wire reset_event_i,
  input wire [3:0] reset_cause_i,
  // Mode register write request.
  output wire mode_write_o,
  output wire [15:0] mode_data_o
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************

  // Synchronised link pins: sclk, inverted select, mosi. The select is
  // inverted so that the cleared flops after reset match its idle level.
  // Without this, a false frame would start and end right after reset.
  wire [2:0] link_sync;
  // Synchronised condition pins.
  wire [18:0] pin_sync;

  sbc_sync #(.WIDTH(3)) link_sync_u (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i({link_sclk_i, ~link_csn_i, link_mosi_i}),
    .sync_o(link_sync)
  );

  sbc_sync #(.WIDTH(19)) pin_sync_u (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .async_i({wake_level_i, temp_warning_i, sw_dev_mode_i,
              enable_output_i, ground_shift_i, mcu_undervolt_i,
              bus_fault_i, aux_overload_i, aux_reg_on_i,
              bus_overload_i, bus_reg_on_i}),
    .sync_o(pin_sync)
  );

  // Named views of the synchronised levels.
  wire sclk_s = link_sync[2];
  wire csn_s = ~link_sync[1];
  wire mosi_s = link_sync[0];
  wire wake_s = pin_sync[18];
  wire temp_s = pin_sync[17];
  wire sdm_s = pin_sync[16];
  wire en_s = pin_sync[15];
  wire gsd_s = pin_sync[14];
  wire uv_s = pin_sync[13];
  wire [8:0] fault_s = pin_sync[12:4];
  wire aux_ovl_s = pin_sync[3];
  wire aux_on_s = pin_sync[2];
  wire bus_ovl_s = pin_sync[1];
  wire bus_on_s = pin_sync[0];

  // ****************************************************************
  // Edge detection on the synchronised link and regulator enables
  // ****************************************************************

  // Previous link levels; csn idles high.
  reg sclk_prev_reg;
  reg csn_prev_reg;
  // Previous regulator enables, for switch-on edges.
  reg aux_on_prev_reg;
  reg bus_on_prev_reg;

  // History registers for every edge detector.
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      sclk_prev_reg <= 1'b0;
      csn_prev_reg <= 1'b1;
      aux_on_prev_reg <= 1'b0;
      bus_on_prev_reg <= 1'b0;
    end else begin
      sclk_prev_reg <= sclk_s;
      csn_prev_reg <= csn_s;
      aux_on_prev_reg <= aux_on_s;
      bus_on_prev_reg <= bus_on_s;
    end
  end

  // Frame start and end, and clock edges inside a frame.
  wire frame_start = csn_prev_reg & ~csn_s;
  wire frame_end = ~csn_prev_reg & csn_s;
  wire sclk_rise = ~csn_s & ~sclk_prev_reg & sclk_s;
  wire sclk_fall = ~csn_s & sclk_prev_reg & ~sclk_s;
  wire aux_on_rise = ~aux_on_prev_reg & aux_on_s;
  wire bus_on_rise = ~bus_on_prev_reg & bus_on_s;

  // ****************************************************************
  // Bus failure code encoder
  // ****************************************************************

  // Encoded failure. Clamping faults take priority because a clamped
  // line hides any wiring fault behind it.
  reg [3:0] fail_code;

  // Priority encoder over the individual fault conditions.
  always @* begin
    if (fault_s[0]) begin
      fail_code = `SBC_F_TXD_DOM;
    end else if (fault_s[1]) begin
      fail_code = `SBC_F_RXD_DOM;
    end else if (fault_s[2]) begin
      fail_code = `SBC_F_BUS_DOM;
    end else if (fault_s[3]) begin
      fail_code = `SBC_F_RXD_REC;
    end else if (fault_s[4]) begin
      fail_code = `SBC_F_H_L;
    end else if (fault_s[5]) begin
      fail_code = `SBC_F_L_SUP;
    end else if (fault_s[6]) begin
      fail_code = `SBC_F_H_GND;
    end else if (fault_s[7]) begin
      fail_code = `SBC_F_L_GND;
    end else if (fault_s[8]) begin
      fail_code = `SBC_F_H_SUP;
    end else begin
      fail_code = `SBC_F_NONE;
    end
  end

  // ****************************************************************
  // Latched diagnosis and status flags
  // ****************************************************************

  // Aux regulator healthy flag.
  reg aux_ok_reg;
  // Bus regulator healthy flag.
  reg bus_ok_reg;
  // Microcontroller supply healthy since last read.
  reg mcu_ok_reg;
  // Supply stayed healthy since the current snapshot.
  reg mcu_ok_since_reg;
  // Power-on flag.
  reg power_on_reg;
  // Most recent reset cause.
  reg [3:0] reset_src_reg;
  // One-cycle pulse: a diagnosis read was recognised.
  reg diag_read_reg;

  // Regulator flags drop on overload and come back on switch-on.
  // The overload wins if both arrive in one cycle.
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      aux_ok_reg <= 1'b1;
      bus_ok_reg <= 1'b1;
    end else begin
      if (aux_ovl_s) begin
        aux_ok_reg <= 1'b0;
      end else if (aux_on_rise) begin
        aux_ok_reg <= 1'b1;
      end
      if (bus_ovl_s) begin
        bus_ok_reg <= 1'b0;
      end else if (bus_on_rise) begin
        bus_ok_reg <= 1'b1;
      end
    end
  end

  // The supply flag is re-armed by a diagnosis read, but only to
  // what was seen after the snapshot; a dip between the snapshot and
  // the read is therefore never lost.
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      mcu_ok_reg <= 1'b1;
      mcu_ok_since_reg <= 1'b1;
    end else begin
      if (uv_s) begin
        mcu_ok_since_reg <= 1'b0;
      end else if (frame_start) begin
        mcu_ok_since_reg <= 1'b1;
      end
      if (uv_s) begin
        mcu_ok_reg <= 1'b0;
      end else if (diag_read_reg) begin
        mcu_ok_reg <= mcu_ok_since_reg;
      end
    end
  end

  // Power-on flag: the set from a power-on event wins over the clear.
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      power_on_reg <= 1'b1;
    end else if (power_on_event_i) begin
      power_on_reg <= 1'b1;
    end else if (normal_entered_i) begin
      power_on_reg <= 1'b0;
    end
  end

  // Reset source is overwritten by every reset event, and no read
  // path touches it.
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      reset_src_reg <= `SBC_RSS_RESET;
    end else if (reset_event_i) begin
      reset_src_reg <= reset_cause_i;
    end
  end

  // ****************************************************************
  // Response words
  // ****************************************************************

  // Live diagnosis word; header and low bits read zero.
  reg [15:0] diag_word;
  // Live status word; wake event bits belong elsewhere, read zero.
  reg [15:0] stat_word;

  // Assemble both words from the live flags.
  always @* begin
    diag_word = 16'h0000;
    diag_word[`SBC_DG_GSD] = gsd_s;
    diag_word[`SBC_DG_FAIL_HI:`SBC_DG_FAIL_LO] = fail_code;
    diag_word[`SBC_DG_V3] = aux_ok_reg;
    diag_word[`SBC_DG_V2] = bus_ok_reg;
    diag_word[`SBC_DG_V1] = mcu_ok_reg;
    stat_word = 16'h0000;
    stat_word[`SBC_ST_RSS_HI:`SBC_ST_RSS_LO] = reset_src_reg;
    stat_word[`SBC_ST_WAKE] = wake_s;
    stat_word[`SBC_ST_TEMP] = temp_s;
    stat_word[`SBC_ST_SDM] = sdm_s;
    stat_word[`SBC_ST_EN] = en_s;
    stat_word[`SBC_ST_PWON] = power_on_reg;
  end

  // ****************************************************************
  // Frame engine
  // ****************************************************************

  // Snapshots taken at frame start.
  reg [15:0] diag_snap_reg;
  reg [15:0] stat_snap_reg;
  // Outgoing shift register, MSB first.
  reg [15:0] tx_reg;
  // Incoming shift register, MSB first.
  reg [15:0] rx_reg;
  // Rising clock edges counted in this frame.
  reg [4:0] bit_cnt_reg;
  // Bit count saturates so an overlong frame never wraps to 16.
  reg overrun_reg;
  // Serial output and its enable.
  reg miso_reg;
  reg miso_oe_reg;
  // Mode register write pulse and data.
  reg mode_write_reg;
  reg [15:0] mode_data_reg;

  // The address is known only after three bits, so the first three
  // answer bits are zero and the chosen snapshot is patched into the
  // still unsent part of the shift register at that moment. Two falling
  // edges have shifted the register by then, so the patch sits two
  // places further towards the top.
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      diag_snap_reg <= 16'h0000;
      stat_snap_reg <= 16'h0000;
      tx_reg <= 16'h0000;
      rx_reg <= 16'h0000;
      bit_cnt_reg <= 5'h00;
      overrun_reg <= 1'b0;
      miso_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
      diag_read_reg <= 1'b0;
      mode_write_reg <= 1'b0;
      mode_data_reg <= 16'h0000;
    end else begin
      diag_read_reg <= 1'b0;
      mode_write_reg <= 1'b0;
      if (frame_start) begin
        // No mode is checked here; reads work in every mode.
        diag_snap_reg <= diag_word;
        stat_snap_reg <= stat_word;
        tx_reg <= 16'h0000;
        bit_cnt_reg <= 5'h00;
        overrun_reg <= 1'b0;
        miso_reg <= 1'b0;
        miso_oe_reg <= 1'b1;
      end else if (frame_end) begin
        miso_oe_reg <= 1'b0;
        // Only a full 16-bit frame with the write bit low is written.
        if (!overrun_reg && bit_cnt_reg == `SBC_FRAME_BITS &&
            rx_reg[15:13] == `SBC_ADDR_DIAG && !rx_reg[`SBC_RO_BIT]) begin
          mode_write_reg <= 1'b1;
          mode_data_reg <= rx_reg;
        end
      end else if (sclk_rise) begin
        rx_reg <= {rx_reg[14:0], mosi_s};
        if (bit_cnt_reg == `SBC_FRAME_BITS) begin
          overrun_reg <= 1'b1;
        end else begin
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
        // Third bit in: all three address bits are known.
        if (bit_cnt_reg == 5'h02) begin
          if ({rx_reg[1:0], mosi_s} == `SBC_ADDR_DIAG) begin
            tx_reg <= {1'b0, diag_snap_reg[12:0], 2'b00};
            diag_read_reg <= 1'b1;
          end else if ({rx_reg[1:0], mosi_s} == `SBC_ADDR_STAT) begin
            tx_reg <= {1'b0, stat_snap_reg[12:0], 2'b00};
          end else begin
            tx_reg <= 16'h0000;
          end
        end
      end else if (sclk_fall) begin
        // Next bit goes out on the falling edge for the host to
        // sample at the end of the following high phase, just before the next falling edge.
        miso_reg <= tx_reg[14];
        tx_reg <= {tx_reg[14:0], 1'b0};
      end
    end
  end

  // Outputs come straight from flip-flops.
  assign link_miso_o = miso_reg;
  assign link_miso_oe_o = miso_oe_reg;
  assign mode_write_o = mode_write_reg;
  assign mode_data_o = mode_data_reg;

endmodule // sbc_status_diag

`default_nettype wire

// ===== tb/sbc_status_diag_asserts.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Port checker for the status and diagnosis block
// ****************************************************************
module sbc_status_diag_asserts (
  input wire core_clk_i,
  input wire rst_i,
  input wire link_sclk_i,
  input wire link_csn_i,
  input wire link_miso_o,
  input wire link_miso_oe_o,
  input wire mode_write_o,
  input wire [15:0] mode_data_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  // The select is synchronised, so the enable trails it by a few cycles.
  a_oe_follows_csn: assert property ($fell(link_csn_i) |-> ##[1:4] link_miso_oe_o)
    else $error("drive enable late after frame start");
  a_oe_idle_off: assert property (link_csn_i [*6] |-> !link_miso_oe_o)
    else $error("drive enable high outside a frame");
  a_oe_in_frame: assert property ($rose(link_miso_oe_o) |-> !link_csn_i)
    else $error("drive enable rose without a frame");
  // Data may move only shortly after the link clock was low.
  a_miso_after_fall: assert property ($changed(link_miso_o) |-> !$past(link_sclk_i, 1)
    || !$past(link_sclk_i, 2) || !$past(link_sclk_i, 3) || !$past(link_sclk_i, 4)
    || !$past(link_sclk_i, 5))
    else $error("data out moved while link clock high");
  a_mw_one_cycle: assert property (mode_write_o |=> !mode_write_o)
    else $error("mode write longer than one cycle");
  a_mw_diag_only: assert property (mode_write_o |-> mode_data_o[15:12] == 4'h2)
    else $error("mode write from a wrong frame header");
  a_mw_after_end: assert property (mode_write_o |-> link_csn_i && $past(link_csn_i))
    else $error("mode write before the frame ended");
  a_data_held: assert property (!mode_write_o |-> $stable(mode_data_o))
    else $error("mode data moved without a write");
  a_rst_quiet: assert property ($fell(rst_i) |-> !link_miso_oe_o && mode_data_o == 16'h0000)
    else $error("outputs not cleared by reset");
endmodule // sbc_status_diag_asserts

bind sbc_status_diag sbc_status_diag_asserts i_sbc_status_diag_asserts (
  .core_clk_i(core_clk_i),
  .rst_i(rst_i),
  .link_sclk_i(link_sclk_i),
  .link_csn_i(link_csn_i),
  .link_miso_o(link_miso_o),
  .link_miso_oe_o(link_miso_oe_o),
  .mode_write_o(mode_write_o),
  .mode_data_o(mode_data_o)
);

`default_nettype wire

// ===== tb/sbc_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Microcontroller side of the serial link
// ****************************************************************
module sbc_host_model (
  input wire core_clk_i,
  input wire link_miso_i,
  input wire link_miso_oe_i,
  output logic link_sclk_o,
  output logic link_csn_o,
  output logic link_mosi_o
);
  // A released data line shows the inverse of its last value, so a late
  // drive enable cannot pass unnoticed.
  wire miso_seen = link_miso_oe_i ? link_miso_i : ~link_miso_i;

  // The link clock stands low between frames.
  initial begin
    link_sclk_o = 1'b0;
    link_csn_o = 1'b1;
    link_mosi_o = 1'b0;
  end

  // Frame of n bits, MSB first; 7 ns offset keeps edges off the core clock.
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    int i;
    rx = 16'h0000;
    @(posedge core_clk_i);
    #7;
    link_csn_o = 1'b0;
    #200;
    for (i = 0; i < n; i++) begin
      link_mosi_o = tx[15 - i];
      #160;
      link_sclk_o = 1'b1;
      #160;
      rx[15 - i] = miso_seen;
      link_sclk_o = 1'b0;
    end
    #160;
    link_csn_o = 1'b1;
    // A released line must not keep showing its last value.
    link_mosi_o = ~link_mosi_o;
    #400;
  endtask
endmodule // sbc_host_model

`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none

// ****************************************************************
// Testbench for the status and diagnosis registers
// ****************************************************************
module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wake = 1'b0;
  logic temp = 1'b0;
  logic sdm = 1'b0;
  logic en = 1'b0;
  logic ground_shift_flag = 1'b0;
  logic uv = 1'b0;
  logic pon = 1'b0;
  logic nrm = 1'b0;
  logic rev = 1'b0;
  logic [1:0] ovl = 2'h0;
  logic [1:0] ron = 2'h0;
  logic [8:0] flt = 9'h000;
  logic [3:0] cause = 4'h0;
  logic [3:0] codes [0:8];
  logic [15:0] rx;
  wire sclk, csn, mosi, miso, oe, mw;
  wire [15:0] mdata;
  int err_total = 0;
  int n_tests = 0;
  int mw_cnt = 0;
  int k;

  initial forever #20 clk = ~clk;

  sbc_status_diag i_sbc_status_diag (.core_clk_i(clk), .rst_i(rst), .link_sclk_i(sclk),
    .link_csn_i(csn), .link_mosi_i(mosi), .link_miso_o(miso), .link_miso_oe_o(oe),
    .wake_level_i(wake), .temp_warning_i(temp), .sw_dev_mode_i(sdm), .enable_output_i(en),
    .ground_shift_i(ground_shift_flag), .mcu_undervolt_i(uv), .bus_fault_i(flt), .aux_overload_i(ovl[0]),
    .aux_reg_on_i(ron[0]), .bus_overload_i(ovl[1]), .bus_reg_on_i(ron[1]),
    .power_on_event_i(pon), .normal_entered_i(nrm), .reset_event_i(rev),
    .reset_cause_i(cause), .mode_write_o(mw), .mode_data_o(mdata));

  sbc_host_model i_sbc_host_model (.core_clk_i(clk), .link_miso_i(miso), .link_miso_oe_i(oe),
    .link_sclk_o(sclk), .link_csn_o(csn), .link_mosi_o(mosi));

  // Count mode write pulses as they happen.
  always @(posedge clk) begin
    if (mw === 1'b1) begin
      mw_cnt <= mw_cnt + 1;
    end
  end

  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    n_tests++;
    if (got !== ex) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // Let the level synchronisers settle before the frame starts.
  task automatic rd(input logic [15:0] f, input logic [15:0] ex);
    repeat (4) @(posedge clk);
    i_sbc_host_model.xfer(f, 16, rx);
    chk("answer", ex, rx);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #1000000;
    err_total++;
    stop_test();
  end

  initial begin
    codes = '{4'hf, 4'he, 4'hc, 4'hd, 4'h9, 4'h8, 4'h6, 4'h5, 4'h4};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk) wake <= 1'b1;
    sdm <= 1'b1;
    rd(16'h1000, 16'h0015);
    @(posedge clk) wake <= 1'b0;
    sdm <= 1'b0;
    temp <= 1'b1;
    en <= 1'b1;
    rd(16'h1000, 16'h000b);
    @(posedge clk) temp <= 1'b0;
    en <= 1'b0;
    @(posedge clk) nrm <= 1'b1;
    @(posedge clk) nrm <= 1'b0;
    rd(16'h1000, 16'h0000);
    @(posedge clk) pon <= 1'b1;
    @(posedge clk) pon <= 1'b0;
    rd(16'h1000, 16'h0001);
    $display("test status levels done");
    @(posedge clk) cause <= 4'ha;
    rev <= 1'b1;
    @(posedge clk) rev <= 1'b0;
    rd(16'h1000, 16'h0a01);
    rd(16'h1000, 16'h0a01);
    @(posedge clk) cause <= 4'h3;
    rev <= 1'b1;
    @(posedge clk) rev <= 1'b0;
    rd(16'h1000, 16'h0301);
    $display("test reset source done");
    rd(16'h3000, 16'h001c);
    @(posedge clk) ground_shift_flag <= 1'b1;
    rd(16'h3000, 16'h081c);
    @(posedge clk) ground_shift_flag <= 1'b0;
    for (k = 0; k < 9; k++) begin
      @(posedge clk) flt <= 9'h001 << k;
      rd(16'h3000, 16'h001c | {5'h00, codes[k], 7'h00});
    end
    @(posedge clk) flt <= 9'h000;
    rd(16'h3000, 16'h001c);
    $display("test failure codes done");
    for (k = 0; k < 2; k++) begin
      @(posedge clk) ovl[k] <= 1'b1;
      repeat (4) @(posedge clk);
      ovl[k] <= 1'b0;
      rd(16'h3000, 16'h001c ^ (16'h0010 >> k));
      @(posedge clk) ron[k] <= 1'b1;
      rd(16'h3000, 16'h001c);
      @(posedge clk) ron[k] <= 1'b0;
    end
    @(posedge clk) uv <= 1'b1;
    repeat (4) @(posedge clk);
    uv <= 1'b0;
    rd(16'h3000, 16'h0018);
    rd(16'h3000, 16'h001c);
    $display("test regulators done");
    k = mw_cnt;
    rd(16'h2abc, 16'h001c);
    chk("writes", 16'(k + 1), 16'(mw_cnt));
    chk("mode", 16'h2abc, mdata);
    rd(16'h3123, 16'h001c);
    rd(16'h0123, 16'h0301);
    rd(16'h4000, 16'h0000);
    i_sbc_host_model.xfer(16'h2456, 8, rx);
    repeat (4) @(posedge clk);
    chk("writes", 16'(k + 1), 16'(mw_cnt));
    chk("mode", 16'h2abc, mdata);
    $display("test mode write done");
    stop_test();
  end
endmodule // testbench

`default_nettype wire
